// ### verilog/gtc_pkg.sv
// package: register map, field positions and constants of the gated 16-bit timer
package gtc_pkg;
    // apb word offsets
    localparam logic [7:0] ADDR_COUNT_LOW  = 8'h00;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h04;
    localparam logic [7:0] ADDR_CONTROL    = 8'h08;
    localparam logic [7:0] ADDR_GATE       = 8'h0c;
    localparam logic [7:0] ADDR_STATUS     = 8'h10;
    localparam logic [7:0] ADDR_MASK       = 8'h14;
    // control register fields
    localparam int CTL_ON     = 0;
    localparam int CTL_SYNCD  = 2;
    localparam int CTL_OSCEN  = 3;
    localparam int CTL_PS_LO  = 4;
    localparam int CTL_SRC_LO = 6;
    // gate register fields
    localparam int GATE_EN  = 0;
    localparam int GATE_POL = 1;
    // status and mask bit
    localparam int ST_OVF = 0;
    // widths
    localparam int COUNT_W = 16;
    localparam int BYTE_W  = 8;
    localparam int PS_W    = 2;
    localparam int PRE_W   = 3;
    localparam int DATA_W  = 32;
    // reset values
    localparam logic [7:0]  CONTROL_RST = 8'h00;
    localparam logic [1:0]  GATE_RST    = 2'h0;
    localparam logic [15:0] COUNT_RST   = 16'h0000;
    localparam logic [15:0] COUNT_MAX   = 16'hffff;
    // instruction clock is the system clock divided by four
    localparam int INSTR_DIV = 4;
    localparam logic [1:0] PHASE_LAST = 2'(INSTR_DIV - 1);
    localparam real CLK_PERIOD_NS = 25.0;
    // clock source codes
    typedef enum logic [1:0] {
        SRC_INSTR = 2'h0,
        SRC_SYS   = 2'h1,
        SRC_EXT   = 2'h2,
        SRC_LFINT = 2'h3
    } src_t;
endpackage

// ### verilog/gated_timer.sv
// gated 16-bit timer/counter with apb register slave
// How it works
// - 16-bit count; byte writes replace live count
// - on bit off stops; gate enable qualifies
// - source field and oscillator enable pick clock
// - instruction clock advances once per four cycles
// - system clock advances four per instruction
// - external pin counts on rising edges
// - external input synchronised or passed through
// - falling edge needed before first rising edge
// - prescaler divides by 1, 2, 4, 8
// - prescaler hidden, cleared by count writes
// - oscillator enable starts crystal, runs asleep
// - overflow wakes only in async external mode
// - rollover FFFFh to 0000h sets overflow flag
// - gated count only while gate equals polarity
// - sync disable bypasses external synchroniser
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/10ps
module gated_timer
    import gtc_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_rstn,
    input  wire logic                  i_psel,
    input  wire logic                  i_penable,
    input  wire logic                  i_pwrite,
    input  wire logic [7:0]            i_paddr,
    input  wire logic [gtc_pkg::DATA_W-1:0] i_pwdata,
    output logic                       o_pready,
    output logic [gtc_pkg::DATA_W-1:0] o_prdata,
    output logic                       o_pslverr,
    input  wire logic                  i_external_count_input,
    input  wire logic                  i_crystal_in_pin,
    input  wire logic                  i_low_freq_internal_osc,
    input  wire logic                  i_gate_input_pin,
    input  wire logic                  i_sleep,
    output logic                       o_crystal_out_pin,
    output logic                       o_sosc_run,
    output logic                       o_wake,
    output logic                       o_irq
);
    import gtc_pkg::*;

    // register state
    logic [COUNT_W-1:0] count_reg;          // live count
    logic [PRE_W-1:0]   pre_reg;            // hidden prescale counter
    logic [1:0]         phase_reg;          // instruction clock phase
    logic               counter_on_reg;     // on bit
    logic               sync_disable_reg;   // bypass synchroniser
    logic               secondary_osc_enable_reg;
    logic [PS_W-1:0]    prescale_select_reg;
    src_t               clock_source_select_reg;
    logic               gate_count_enable_reg;
    logic               gate_polarity_reg;
    logic               status_reg;         // sticky overflow flag
    logic               mask_reg;           // interrupt mask
    logic               ext_s1_reg;         // synchroniser first stage
    logic               ext_s2_reg;         // synchroniser second stage
    logic               ext_raw_reg;        // unsynchronised sample
    logic               osc_lvl_reg;        // crystal / lfint sample
    logic               lvl_prev_reg;       // previous source level
    logic               armed_reg;          // falling edge seen
    logic               on_prev_reg;        // on bit, last cycle
    logic               pready_reg;
    logic [DATA_W-1:0]  prdata_reg;
    logic               pslverr_reg;
    logic               irq_reg;
    logic               wake_reg;
    logic               xout_reg;
    logic               sosc_run_reg;

    // combinational helpers
    logic               acc;                // apb access completing
    logic               wr;                 // write taking effect
    logic               wr_low;
    logic               wr_high;
    logic               wr_count;
    logic               mapped;
    logic               ext_lvl;
    logic               src_lvl;
    logic               rise;
    logic               fall;
    logic               tick;
    logic               gate_ok;
    logic               async_ext;
    logic               run;
    logic [PRE_W-1:0]   pre_mask;
    logic               inc;
    logic               ovf;
    logic [DATA_W-1:0]  rdata_next;

    // apb decode: one wait state, answer comes from flops
    assign acc      = i_psel & i_penable & pready_reg;
    assign wr       = acc & i_pwrite;
    assign wr_low   = wr & (i_paddr == ADDR_COUNT_LOW);
    assign wr_high  = wr & (i_paddr == ADDR_COUNT_HIGH);
    assign wr_count = wr_low | wr_high;
    assign mapped   = (i_paddr == ADDR_COUNT_LOW) | (i_paddr == ADDR_COUNT_HIGH)
                    | (i_paddr == ADDR_CONTROL) | (i_paddr == ADDR_GATE)
                    | (i_paddr == ADDR_STATUS) | (i_paddr == ADDR_MASK);

    // pass-through uses one flop instead of two, at the cost of metastability margin
    assign ext_lvl = sync_disable_reg ? ext_raw_reg : ext_s2_reg;

    // source level for edge detection
    always_comb begin
        if (clock_source_select_reg == SRC_EXT && !secondary_osc_enable_reg) begin
            src_lvl = ext_lvl;
        end else begin
            src_lvl = osc_lvl_reg;  // crystal or low-frequency oscillator
        end
    end

    assign rise = src_lvl & ~lvl_prev_reg;
    assign fall = ~src_lvl & lvl_prev_reg;

    // source tick selection
    always_comb begin
        unique case (clock_source_select_reg)
            SRC_INSTR: tick = (phase_reg == PHASE_LAST);
            SRC_SYS:   tick = 1'b1;
            SRC_EXT:   tick = rise & armed_reg;
            SRC_LFINT: tick = rise;
        endcase
    end

    // enable: on bit, gate, and sleep
    assign gate_ok   = ~gate_count_enable_reg
                     | (i_gate_input_pin == gate_polarity_reg);
    assign async_ext = (clock_source_select_reg == SRC_EXT) & sync_disable_reg;
    assign run       = counter_on_reg & gate_ok & (~i_sleep | async_ext);

    // prescaler pulse once its selected low bits are all ones
    assign pre_mask = PRE_W'((1 << prescale_select_reg) - 1);
    assign inc      = tick & run & ((pre_reg & pre_mask) == pre_mask);
    assign ovf      = inc & (count_reg == COUNT_MAX) & ~wr_count;

    // instruction clock phase, free running
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    // input sampling; first stage feeds only the second
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ext_s1_reg  <= 1'b0;
            ext_s2_reg  <= 1'b0;
            ext_raw_reg <= 1'b0;
            osc_lvl_reg <= 1'b0;
        end else begin
            ext_s1_reg  <= i_external_count_input;
            ext_s2_reg  <= ext_s1_reg;
            ext_raw_reg <= i_external_count_input;
            osc_lvl_reg <= (clock_source_select_reg == SRC_LFINT) ?
                           i_low_freq_internal_osc : i_crystal_in_pin;
        end
    end

    // edge history and on-bit history
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            lvl_prev_reg <= 1'b0;
            on_prev_reg  <= 1'b0;
        end else begin
            lvl_prev_reg <= src_lvl;
            on_prev_reg  <= counter_on_reg;
        end
    end

    // arm flag: an on-bit change, the off state or a count write demands a fresh falling edge
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            armed_reg <= 1'b0;
        end else if (wr_count || (counter_on_reg != on_prev_reg) || !counter_on_reg) begin
            armed_reg <= 1'b0;
        end else if (fall) begin
            armed_reg <= 1'b1;
        end
    end

    // prescale counter, never visible on the bus
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pre_reg <= '0;
        end else if (wr_count) begin
            pre_reg <= '0;
        end else if (tick && run) begin
            pre_reg <= pre_reg + PRE_W'(1);
        end
    end

    // live count; a byte write beats a concurrent increment
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            count_reg <= COUNT_RST;
        end else if (wr_count) begin
            if (wr_low) begin
                count_reg[BYTE_W-1:0] <= i_pwdata[BYTE_W-1:0];
            end else begin
                count_reg[COUNT_W-1:BYTE_W] <= i_pwdata[BYTE_W-1:0];
            end
        end else if (inc) begin
            count_reg <= count_reg + COUNT_W'(1);
        end
    end

    // control and gate registers
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            counter_on_reg           <= CONTROL_RST[CTL_ON];
            sync_disable_reg         <= CONTROL_RST[CTL_SYNCD];
            secondary_osc_enable_reg <= CONTROL_RST[CTL_OSCEN];
            prescale_select_reg      <= CONTROL_RST[CTL_PS_LO +: PS_W];
            clock_source_select_reg  <= src_t'(CONTROL_RST[CTL_SRC_LO +: 2]);
            gate_count_enable_reg    <= GATE_RST[GATE_EN];
            gate_polarity_reg        <= GATE_RST[GATE_POL];
        end else if (wr && i_paddr == ADDR_CONTROL) begin
            counter_on_reg           <= i_pwdata[CTL_ON];
            sync_disable_reg         <= i_pwdata[CTL_SYNCD];
            secondary_osc_enable_reg <= i_pwdata[CTL_OSCEN];
            prescale_select_reg      <= i_pwdata[CTL_PS_LO +: PS_W];
            clock_source_select_reg  <= src_t'(i_pwdata[CTL_SRC_LO +: 2]);
        end else if (wr && i_paddr == ADDR_GATE) begin
            gate_count_enable_reg <= i_pwdata[GATE_EN];
            gate_polarity_reg     <= i_pwdata[GATE_POL];
        end
    end

    // sticky overflow: a rollover in the clearing cycle still sets it
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            status_reg <= 1'b0;
            mask_reg   <= 1'b0;
        end else begin
            if (ovf) begin
                status_reg <= 1'b1;
            end else if (wr && i_paddr == ADDR_STATUS && i_pwdata[ST_OVF]) begin
                status_reg <= 1'b0;
            end
            if (wr && i_paddr == ADDR_MASK) begin
                mask_reg <= i_pwdata[ST_OVF];
            end
        end
    end

    // interrupt, wake and oscillator outputs
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_reg      <= 1'b0;
            wake_reg     <= 1'b0;
            xout_reg     <= 1'b0;
            sosc_run_reg <= 1'b0;
        end else begin
            irq_reg      <= status_reg & mask_reg;
            wake_reg     <= ovf & i_sleep & async_ext;
            // inverting crystal drive; sleep does not stop it
            xout_reg     <= secondary_osc_enable_reg & ~i_crystal_in_pin;
            sosc_run_reg <= secondary_osc_enable_reg;
        end
    end

    // read mux; unmapped reads return zero
    always_comb begin
        rdata_next = '0;
        unique case (i_paddr)
            ADDR_COUNT_LOW:  rdata_next[BYTE_W-1:0] = count_reg[BYTE_W-1:0];
            ADDR_COUNT_HIGH: rdata_next[BYTE_W-1:0] = count_reg[COUNT_W-1:BYTE_W];
            ADDR_CONTROL: begin
                rdata_next[CTL_ON]             = counter_on_reg;
                rdata_next[CTL_SYNCD]          = sync_disable_reg;
                rdata_next[CTL_OSCEN]          = secondary_osc_enable_reg;
                rdata_next[CTL_PS_LO +: PS_W]  = prescale_select_reg;
                rdata_next[CTL_SRC_LO +: 2]    = clock_source_select_reg;
            end
            ADDR_GATE: begin
                rdata_next[GATE_EN]  = gate_count_enable_reg;
                rdata_next[GATE_POL] = gate_polarity_reg;
            end
            ADDR_STATUS: rdata_next[ST_OVF] = status_reg;
            ADDR_MASK:   rdata_next[ST_OVF] = mask_reg;
            default:     rdata_next = '0;
        endcase
    end

    // apb answer: pready one cycle into the access phase
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= '0;
            pslverr_reg <= 1'b0;
        end else if (i_psel && i_penable && !pready_reg) begin
            pready_reg  <= 1'b1;
            prdata_reg  <= i_pwrite ? '0 : rdata_next;
            pslverr_reg <= ~mapped;
        end else begin
            pready_reg  <= 1'b0;
            prdata_reg  <= '0;
            pslverr_reg <= 1'b0;
        end
    end

    assign o_pready          = pready_reg;
    assign o_prdata          = prdata_reg;
    assign o_pslverr         = pslverr_reg;
    assign o_irq             = irq_reg;
    assign o_wake            = wake_reg;
    assign o_crystal_out_pin = xout_reg;
    assign o_sosc_run        = sosc_run_reg;

    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_low_write;
        wr_low;
    endsequence

    a_low_byte_write: assert property (s_low_write |=>
        count_reg[BYTE_W-1:0] == $past(i_pwdata[BYTE_W-1:0]))
        else $error("low byte write not applied");
    a_prescale_clear: assert property (wr_count |=> pre_reg == '0)
        else $error("prescaler not cleared by count write");
    a_off_holds: assert property (!counter_on_reg && !wr_count |=> $stable(count_reg))
        else $error("count moved while off");
    a_rollover_flag: assert property (ovf |=> status_reg && count_reg == COUNT_RST)
        else $error("rollover did not wrap and flag");
    a_instr_rate: assert property (
        inc && clock_source_select_reg == SRC_INSTR |=> !inc [*3])
        else $error("instruction clock stepped too fast");
    a_sys_rate: assert property (
        run && clock_source_select_reg == SRC_SYS && prescale_select_reg == 2'h0
        && !wr_count |=> count_reg == $past(count_reg) + COUNT_W'(1))
        else $error("system clock did not step each cycle");
    a_gate_hold: assert property (
        gate_count_enable_reg && i_gate_input_pin != gate_polarity_reg |-> !inc)
        else $error("counted while gated off");
    a_arm_needed: assert property (
        clock_source_select_reg == SRC_EXT && !armed_reg |-> !inc)
        else $error("external count before falling edge");
    a_osc_run: assert property (secondary_osc_enable_reg |=> o_sosc_run)
        else $error("oscillator not running when enabled");
    a_wake_only: assert property (
        o_wake |-> $past(async_ext) && $past(i_sleep))
        else $error("wake outside async external sleep");
endmodule

// ### tb/xtal_model.sv
// partner: secondary crystal oscillator as seen at the crystal input pin
`timescale 1ns/10ps
module xtal_model #(
    parameter int HALF = 2  // half period in system clocks
) (
    input  wire logic i_clk,
    input  wire logic i_drive,  // amplifier enable from the device
    output logic      o_osc
);
    int cnt;  // cycles spent in the current half period

    initial begin
        o_osc = 1'h0;
        cnt = 0;
    end

    // swings only while the device drives it; a stopped crystal rests low
    always @(posedge i_clk) begin
        if (i_drive !== 1'h1) begin
            o_osc <= 1'h0;
            cnt <= 0;
        end else if (cnt == HALF - 1) begin
            o_osc <= ~o_osc;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// ### tb/tb_top.sv
// self-checking bench for the gated 16-bit timer
`timescale 1ns/10ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (got), (exp)); end end
module tb_top;
    import gtc_pkg::*;
    typedef struct packed {
        logic [7:0] ctrl;  // control byte
        logic [1:0] gate;  // gate register
        logic       pin;   // gate pin level
        logic [7:0] exp;   // expected low count byte
    } row_t;
    logic        clk, rstn, psel, penable, pwrite, pready, pslverr;  // apb side
    logic [7:0]  paddr;                                              // byte address
    logic [31:0] pwdata, prdata, rd;                                 // data words
    logic        er, ext_pin, xtal, gate_pin, sleep, xout, run, wake, irq;
    logic        xtal_seen;                                          // crystal level last edge
    logic [1:0]  lf_div;                                             // slow oscillator divider
    int          errors, compares, wakes, n;                         // bookkeeping
    // 16 edges of counting per row: 12 idle cycles plus the bus latency
    row_t rows [12] = '{'{8'h41, 2'h0, 1'h0, 8'h10}, '{8'h51, 2'h0, 1'h0, 8'h08},
        '{8'h61, 2'h0, 1'h0, 8'h04}, '{8'h71, 2'h0, 1'h0, 8'h02},
        '{8'h01, 2'h0, 1'h0, 8'h04}, '{8'h11, 2'h0, 1'h0, 8'h02},
        '{8'h40, 2'h0, 1'h0, 8'h00}, '{8'h40, 2'h1, 1'h1, 8'h00},
        '{8'h41, 2'h3, 1'h1, 8'h10}, '{8'h41, 2'h3, 1'h0, 8'h00},
        '{8'h41, 2'h1, 1'h0, 8'h10}, '{8'hc1, 2'h0, 1'h0, 8'h04}};
    logic [7:0] ext_ctl [2] = '{8'h81, 8'h85};  // synchronised, then bypassed
    logic [7:0] zero_addr [6] = '{ADDR_COUNT_LOW, ADDR_COUNT_HIGH, ADDR_CONTROL, ADDR_GATE,
        ADDR_STATUS, ADDR_MASK};

    gated_timer uut (
        .i_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .i_external_count_input(ext_pin),
        .i_crystal_in_pin(xtal), .i_low_freq_internal_osc(lf_div[1]),
        .i_gate_input_pin(gate_pin), .i_sleep(sleep), .o_crystal_out_pin(xout),
        .o_sosc_run(run), .o_wake(wake), .o_irq(irq)
    );
    xtal_model #(.HALF(2)) xtal_src (.i_clk(clk), .i_drive(run), .o_osc(xtal));

    // free-running 40 MHz clock
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    // wake pulses are single cycles, so count them as they pass
    initial wakes = 0;
    always @(posedge clk) if (wake === 1'h1) wakes++;

    // slow oscillator stand-in: one rising edge every four clocks
    initial lf_div = 2'h0;
    always @(posedge clk) lf_div <= lf_div + 2'h1;

    // crystal level exactly as the design sampled it at the last edge
    always @(posedge clk) xtal_seen <= xtal;

    // verdict and end of run
    task automatic finish_test();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // one apb transfer, entered just after a rising edge; idles one cycle after
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        if (pready !== 1'h1) begin
            errors++; // slave never answered
            finish_test();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask

    // reset held for 16 cycles, released after an edge
    task automatic do_reset();
        rstn <= 1'h0;
        repeat (16) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
    endtask

    // count, control, gate, status and mask all come out of reset cleared
    task automatic check_zero();
        foreach (zero_addr[k]) begin
            bus(1'h0, zero_addr[k], 32'h0, rd, er);
            `CHK(rd, 32'h0)
        end
        `CHK(irq, 1'h0)
    endtask

    // external pin step with time for the synchroniser to settle
    task automatic pin(input logic v);
        ext_pin <= v;
        repeat (6) @(posedge clk);
    endtask

    initial begin
        rstn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ext_pin = 1'h0;
        gate_pin = 1'h0;
        sleep = 1'h0;
        errors = 0;
        compares = 0;
        do_reset();
        check_zero();
        // counting modes, prescale and enable combinations
        foreach (rows[i]) begin
            gate_pin <= rows[i].pin;
            bus(1'h1, ADDR_GATE, 32'(rows[i].gate), rd, er);
            bus(1'h1, ADDR_CONTROL, 32'(rows[i].ctrl), rd, er);
            bus(1'h1, ADDR_COUNT_LOW, 32'h0, rd, er);
            repeat (12) @(posedge clk);
            bus(1'h1, ADDR_CONTROL, 32'h0, rd, er);
            bus(0, ADDR_COUNT_LOW, 32'h0, rd, er);
            `CHK(rd, {24'h0, rows[i].exp})
        end
        bus(1'h1, ADDR_GATE, 32'h0, rd, er);
        // first rise after a count write is ignored until a fall is seen
        foreach (ext_ctl[k]) begin
            ext_pin <= 1'h0;
            bus(1'h1, ADDR_CONTROL, 32'(ext_ctl[k]), rd, er);
            bus(1'h1, ADDR_COUNT_LOW, 32'h0, rd, er);
            pin(1'h1);
            pin(1'h0);
            pin(1'h1);
            bus(1'h0, ADDR_COUNT_LOW, 32'h0, rd, er);
            `CHK(rd, 32'h1)
        end
        // crystal settle: clear flag, preload fc00, sleep in async mode
        bus(1'h1, ADDR_CONTROL, 32'h0, rd, er);
        bus(1'h1, ADDR_STATUS, 32'h1, rd, er);
        bus(1'h1, ADDR_MASK, 32'h1, rd, er);
        bus(1'h1, ADDR_COUNT_HIGH, 32'hfc, rd, er);
        bus(1'h1, ADDR_COUNT_LOW, 32'h0, rd, er);
        bus(1'h0, ADDR_COUNT_HIGH, 32'h0, rd, er);
        `CHK(rd, 32'hfc)
        sleep <= 1'h1;
        bus(1'h1, ADDR_CONTROL, 32'h8d, rd, er);
        repeat (3900) @(posedge clk);
        // look between edges, where the registered pins have settled
        @(negedge clk);
        `CHK(run, 1'h1)
        `CHK(xout, ~xtal_seen)
        `CHK(irq, 1'h0)
        n = 0;
        while (irq !== 1'h1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        `CHK(irq, 1'h1)
        `CHK(wakes, 1)
        sleep <= 1'h0;
        bus(1'h1, ADDR_CONTROL, 32'h0, rd, er);
        // masking and write-one-to-clear
        bus(1'h1, ADDR_MASK, 32'h0, rd, er);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'h0)
        bus(1'h1, ADDR_MASK, 32'h1, rd, er);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'h1)
        bus(1'h1, ADDR_STATUS, 32'h1, rd, er);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'h0)
        // unmapped address answers with an error and no data
        bus(1'h0, 8'h18, 32'h0, rd, er);
        `CHK(er, 1'h1)
        `CHK(rd, 32'h0)
        // second reset in mid-run
        bus(1'h1, ADDR_CONTROL, 32'h41, rd, er);
        do_reset();
        check_zero();
        finish_test();
    end
endmodule
